// ### verilog/pir_sens_map.svh
// constants for the motion sensitivity interlock: register offsets, fields, resets, timing
// assumes inclusion by design modules and by the checker and bench
`ifndef PIR_SENS_MAP_SVH
`define PIR_SENS_MAP_SVH

// ******************************
// register offsets (byte addresses)
// ******************************
`define OFS_SECTOR_SENS     12'h000
`define OFS_ROUTE           12'h004
`define OFS_CONFIG          12'h008
`define OFS_LOCKOUT_TIME    12'h00c
`define OFS_REMOTE_SENS     12'h010
`define OFS_STATUS          12'h014
`define OFS_EFFECTIVE_SENS  12'h018

// ******************************
// fields
// ******************************
`define SENS_W              4
`define SENS_MAX            4'hf
`define CFG_BASIC_LOW_BIT   0
`define CFG_BASIC_OK_BIT    1
`define STAT_LOCK_BIT       0
`define ROUTE_W             5
`define LOCK_W              16
`define ADJ_DOWN            2'h0
`define ADJ_MID             2'h1
`define ADJ_UP              2'h2

// ******************************
// reset values and the basic low offset
// ******************************
`define RST_SENS            12'h888
`define RST_ROUTE           15'h7fff
`define RST_LOCKOUT_TIME    16'h000a
`define BASIC_LOW_OFFSET    4'h2

// ******************************
// timing: lockout tick every 100 ms
// ******************************
`define CLK_HZ              10000000
`define TICK_MS             100
`define TICK_CYCLES         (`CLK_HZ / 1000 * `TICK_MS)

`endif

// ### verilog/pir_sens_pkg.sv
// types shared by the motion sensitivity interlock
// assumes the map header carries every number
package pir_sens_pkg;
	typedef enum logic [1:0] {
		src_config,
		src_adjuster,
		src_remote
	} sens_source_type;

	typedef enum logic [1:0] {
		bus_idle,
		bus_write_resp,
		bus_read_resp
	} bus_state_type;
endpackage

// ### verilog/pin_sync.sv
// three-flop synchroniser with agreement of the last two stages
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_d;

	// change accepted only when stages two and three agree
	assign level_d = (s2_q == s3_q) ? s3_q : level;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			level <= '0;
		end else begin
			s1_q  <= pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			level <= level_d;
		end
	end
endmodule

// ### verilog/pir_motion_sensitivity_interlock.sv
// motion evaluation: sector sensitivity resolution, detection block routing, lockout
// assumes AXI4-Lite master on clk, sector motion and adjuster from pins
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "pir_sens_map.svh"

// Contract
// - Motion is evaluated through three independent sectors of 120 degrees covering the full circle.
// - Each sector keeps its own configured sensitivity, changeable later by adjuster and remote control.
// - Each sector may be routed to any of five detection blocks, each fed only its assigned sectors.
// - The three-position adjuster shifts all sectors together by minus one, zero or plus one level.
// - Effective sensitivity follows the latest of download, adjuster move or remote command.
// - After download or remote change the adjuster position is ignored until it is moved again.
// - A global basic sensitivity of high or low is kept; low lowers all sectors by a fixed amount.
// - When basic sensitivity is unsupported the device always works with high basic sensitivity.
// - A matching status telegram on the lockout input suppresses detection for the lockout time.
// - A further matching telegram during lockout restarts the full lockout time.
module pir_motion_sensitivity_interlock
	import pir_sens_pkg::*;
#(
	parameter int NUM_SECTORS = 3,
	parameter int NUM_BLOCKS  = `ROUTE_W,
	parameter int TICK_COUNT  = `TICK_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [11:0]                   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [11:0]                   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [NUM_SECTORS-1:0]        sector_motion,
	input  wire logic [1:0]                    adjuster_pos,
	input  wire logic                          motion_lockout_input,
	output logic [NUM_SECTORS*`SENS_W-1:0]     sector_threshold,
	output logic [NUM_BLOCKS-1:0]              detection_block,
	output logic                               lockout_active
);
	localparam int SW = `SENS_W;

	// ******************************
	// pin synchronisation
	// ******************************
	logic [NUM_SECTORS-1:0] motion_s;
	logic [1:0]             adj_s;
	logic                   lock_s;

	pin_sync #(.WIDTH(NUM_SECTORS + 3)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   ({sector_motion, adjuster_pos, motion_lockout_input}),
		.level ({motion_s, adj_s, lock_s})
	);

	// ******************************
	// register bus slave
	// ******************************
	bus_state_type          bus_q;
	logic [11:0]            awaddr_q;
	logic                   aw_have_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   w_have_q;
	logic [NUM_SECTORS*SW-1:0] cfg_sens_q;
	logic [NUM_SECTORS*NUM_BLOCKS-1:0] route_q;
	logic [1:0]             cfg_q;
	logic [`LOCK_W-1:0]     lock_time_q;
	logic [NUM_SECTORS*SW-1:0] eff_sens_q;
	logic [`LOCK_W-1:0]     lock_cnt_q;
	logic [5:0]             adj_seen_q;
	logic [1:0]             adj_last_q;

	wire aw_take   = s_axi_awvalid && s_axi_awready;
	wire w_take    = s_axi_wvalid && s_axi_wready;
	wire wr_go     = (bus_q == bus_idle) && (aw_have_q || aw_take) && (w_have_q || w_take);
	wire [11:0] wr_addr   = aw_have_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data   = w_have_q ? wdata_q : s_axi_wdata;
	wire [3:0]  wr_strb   = w_have_q ? wstrb_q : s_axi_wstrb;
	wire rd_go     = (bus_q == bus_idle) && !wr_go && s_axi_arvalid;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic known(input logic [11:0] a);
		return a == `OFS_SECTOR_SENS || a == `OFS_ROUTE || a == `OFS_CONFIG ||
			a == `OFS_LOCKOUT_TIME || a == `OFS_REMOTE_SENS || a == `OFS_STATUS ||
			a == `OFS_EFFECTIVE_SENS;
	endfunction

	wire wr_sens   = wr_go && wr_addr == `OFS_SECTOR_SENS;
	wire wr_remote = wr_go && wr_addr == `OFS_REMOTE_SENS;
	wire wr_route  = wr_go && wr_addr == `OFS_ROUTE;
	wire wr_cfg    = wr_go && wr_addr == `OFS_CONFIG;
	wire wr_ltime  = wr_go && wr_addr == `OFS_LOCKOUT_TIME;
	wire [31:0] sens_merged = merge(32'(cfg_sens_q), wr_data, wr_strb);
	wire [31:0] rem_merged  = merge(32'(eff_sens_q), wr_data, wr_strb);
	wire [31:0] route_merged = merge(32'(route_q), wr_data, wr_strb);
	wire [31:0] cfg_merged   = merge(32'(cfg_q), wr_data, wr_strb);
	wire [31:0] ltime_merged = merge(32'(lock_time_q), wr_data, wr_strb);

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`OFS_SECTOR_SENS:    rd_mux = 32'(cfg_sens_q);
			`OFS_ROUTE:          rd_mux = 32'(route_q);
			`OFS_CONFIG:         rd_mux = 32'(cfg_q);
			`OFS_LOCKOUT_TIME:   rd_mux = 32'(lock_time_q);
			`OFS_REMOTE_SENS:    rd_mux = 32'(eff_sens_q);
			`OFS_STATUS:         rd_mux = {15'h0000, lock_cnt_q, lockout_active};
			`OFS_EFFECTIVE_SENS: rd_mux = 32'(sector_threshold);
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q         <= bus_idle;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'h0;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			if (aw_take && !wr_go) begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take && !wr_go) begin
				w_have_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			case (bus_q)
				bus_idle: begin
					if (wr_go) begin
						bus_q         <= bus_write_resp;
						aw_have_q     <= 1'b0;
						w_have_q      <= 1'b0;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
						s_axi_arready <= 1'b0;
						s_axi_bvalid  <= 1'b1;
						s_axi_bresp   <= known(wr_addr) ? 2'h0 : 2'h2;
					end else if (rd_go) begin
						bus_q         <= bus_read_resp;
						s_axi_arready <= 1'b0;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_mux;
						s_axi_rresp   <= known(s_axi_araddr) ? 2'h0 : 2'h2;
					end
				end
				bus_write_resp: begin
					if (s_axi_bready) begin
						bus_q         <= bus_idle;
						s_axi_bvalid  <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready  <= 1'b1;
						s_axi_arready <= 1'b1;
					end
				end
				bus_read_resp: begin
					if (s_axi_rready) begin
						bus_q         <= bus_idle;
						s_axi_rvalid  <= 1'b0;
						s_axi_awready <= !aw_have_q;
						s_axi_wready  <= !w_have_q;
						s_axi_arready <= 1'b1;
					end
				end
				default: bus_q <= bus_idle;
			endcase
		end
	end

	// ******************************
	// configuration registers
	// ******************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_sens_q  <= `RST_SENS;
			route_q     <= `RST_ROUTE;
			cfg_q       <= 2'h0;
			lock_time_q <= `RST_LOCKOUT_TIME;
		end else begin
			if (wr_sens) cfg_sens_q <= sens_merged[NUM_SECTORS*SW-1:0];
			if (wr_route) route_q <= route_merged[NUM_SECTORS*NUM_BLOCKS-1:0];
			if (wr_cfg) cfg_q <= cfg_merged[1:0];
			if (wr_ltime) lock_time_q <= ltime_merged[`LOCK_W-1:0];
		end
	end

	// ******************************
	// sensitivity resolution
	// ******************************
	// adjuster acts only on a move; download and remote disarm it until then
	wire adj_moved = adj_s != adj_last_q;
	logic [NUM_SECTORS*SW-1:0] adj_sens;
	logic [NUM_SECTORS*SW-1:0] thr_d;
	wire basic_low = cfg_q[`CFG_BASIC_LOW_BIT] && cfg_q[`CFG_BASIC_OK_BIT];

	genvar g;
	generate
		for (g = 0; g < NUM_SECTORS; g++) begin : g_sec
			wire [SW-1:0] base = cfg_sens_q[g*SW +: SW];
			// shift is from the configured value, one level at most
			assign adj_sens[g*SW +: SW] = (adj_s == `ADJ_UP) ? ((base == `SENS_MAX) ? base : base + 1'b1) :
				(adj_s == `ADJ_DOWN) ? ((base == '0) ? base : base - 1'b1) : base;
			wire [SW-1:0] e = eff_sens_q[g*SW +: SW];
			// low basic sensitivity subtracts a fixed amount, floored at zero
			assign thr_d[g*SW +: SW] = !basic_low ? e :
				(e > `BASIC_LOW_OFFSET ? e - `BASIC_LOW_OFFSET : '0);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eff_sens_q <= `RST_SENS;
			adj_last_q <= `ADJ_MID;
			adj_seen_q <= '0;
		end else begin
			adj_last_q <= adj_s;
			// latest action wins; bus writes outrank a move in the same cycle
			if (wr_sens) begin
				eff_sens_q <= sens_merged[NUM_SECTORS*SW-1:0];
			end else if (wr_remote) begin
				eff_sens_q <= rem_merged[NUM_SECTORS*SW-1:0];
			end else if (adj_moved && adj_seen_q[5]) begin
				eff_sens_q <= adj_sens;
			end
			// synchroniser comes out of reset at zero, not at the pin level;
			// stay disarmed until it has filled so that step is no move
			adj_seen_q <= {adj_seen_q[4:0], 1'b1};
		end
	end

	// ******************************
	// lockout timer and routing
	// ******************************
	logic [31:0] tick_cnt_q;
	wire tick = tick_cnt_q == 32'(TICK_COUNT - 1);
	logic lock_prev_q;
	wire lock_evt = lock_s != lock_prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q  <= 32'h0000_0000;
			lock_prev_q <= 1'b0;
			lock_cnt_q  <= '0;
		end else begin
			tick_cnt_q  <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			lock_prev_q <= lock_s;
			if (lock_evt) lock_cnt_q <= lock_time_q;
			else if (tick && lock_cnt_q != '0) lock_cnt_q <= lock_cnt_q - 1'b1;
		end
	end

	wire [NUM_SECTORS-1:0] motion_ok = (lock_cnt_q != '0) ? '0 : motion_s;
	logic [NUM_BLOCKS-1:0] block_d;
	generate
		for (g = 0; g < NUM_BLOCKS; g++) begin : g_blk
			logic [NUM_SECTORS-1:0] sel;
			for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_sel
				assign sel[s] = route_q[s*NUM_BLOCKS + g];
			end
			assign block_d[g] = |(motion_ok & sel);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detection_block  <= '0;
			sector_threshold <= '0;
			lockout_active   <= 1'b0;
		end else begin
			detection_block  <= block_d;
			sector_threshold <= thr_d;
			lockout_active   <= lock_cnt_q != '0;
		end
	end
endmodule

// ### dv/lamp_status_model.sv
// luminaire status source for the motion lockout input
// assumes the bench sets lamp_on just after a rising edge
`timescale 1ns/1ns
module lamp_status_model (
	input	wire logic	clk,
	input	wire logic	rst_n,
	input	wire logic	lamp_on,
	output	logic		status
);
	// ****************
	// status telegram
	// ****************
	// every lamp switching is reported one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= 1'b0;
		end else begin
			status <= lamp_on;
		end
	end
endmodule

// ### dv/pir_lock_props.sv
// assertion checker for the motion sensitivity interlock
// assumes only the top module ports and the map header
`timescale 1ns/1ns
`include "pir_sens_map.svh"
module pir_lock_props #(
	parameter int NUM_SECTORS = 3,
	parameter int NUM_BLOCKS = 5
) (
	input	wire logic	clk,
	input	wire logic	rst_n,
	input	wire logic [11:0]	s_axi_awaddr,
	input	wire logic	s_axi_awvalid,
	input	wire logic	s_axi_awready,
	input	wire logic [31:0]	s_axi_wdata,
	input	wire logic [3:0]	s_axi_wstrb,
	input	wire logic	s_axi_wvalid,
	input	wire logic	s_axi_wready,
	input	wire logic [1:0]	s_axi_bresp,
	input	wire logic	s_axi_bvalid,
	input	wire logic	s_axi_bready,
	input	wire logic [11:0]	s_axi_araddr,
	input	wire logic	s_axi_arvalid,
	input	wire logic	s_axi_arready,
	input	wire logic [31:0]	s_axi_rdata,
	input	wire logic [1:0]	s_axi_rresp,
	input	wire logic	s_axi_rvalid,
	input	wire logic	s_axi_rready,
	input	wire logic [NUM_SECTORS-1:0]	sector_motion,
	input	wire logic [1:0]	adjuster_pos,
	input	wire logic	motion_lockout_input,
	input	wire logic [NUM_SECTORS*`SENS_W-1:0]	sector_threshold,
	input	wire logic [NUM_BLOCKS-1:0]	detection_block,
	input	wire logic	lockout_active
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_W_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write not answered");
	AST_R_RESP: assert property (s_axi_arvalid && s_axi_arready && !s_axi_awvalid && !s_axi_wvalid |=> s_axi_rvalid)
		else $error("read not answered");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response changed");
	AST_BUSY: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while response pending");
	AST_LOCK_OUT: assert property (lockout_active [*2] |-> detection_block == '0)
		else $error("motion passed during lockout");
	AST_IDLE_OUT: assert property ((sector_motion == '0) [*8] |-> detection_block == '0)
		else $error("block active without motion");
	// a lockout time of at least two ticks is assumed here
	AST_LOCK_HOLD: assert property ($changed(motion_lockout_input) |-> ##[3:6] lockout_active ##1 lockout_active [*4])
		else $error("lockout missing after telegram");
	COV_WR: cover property (s_axi_bvalid && s_axi_bready);
	COV_RD: cover property (s_axi_rvalid && s_axi_rready);
	COV_LOCK: cover property ($rose(lockout_active) && sector_motion != '0);
endmodule
bind pir_motion_sensitivity_interlock pir_lock_props #(.NUM_SECTORS(NUM_SECTORS), .NUM_BLOCKS(NUM_BLOCKS)) props (.*);

// ### dv/pir_motion_sensitivity_interlock_tb.sv
// self-checking bench for the motion sensitivity interlock
// assumes a short tick count and the lamp status model
`timescale 1ns/1ns
`include "pir_sens_map.svh"
module pir_motion_sensitivity_interlock_tb;
	logic	clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic	s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, motion_lockout_input, lamp_on, lockout_active;
	logic [11:0]	s_axi_awaddr, s_axi_araddr, sector_threshold, cfg, rem;
	logic [31:0]	s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp, adjuster_pos, rsp;
	logic [2:0]	sector_motion;
	logic [4:0]	detection_block;
	logic [14:0]	rt;
	int	fail_count, checked, cyc;

	pir_motion_sensitivity_interlock #(.TICK_COUNT(4)) dut (.*);
	lamp_status_model lamp (.clk(clk), .rst_n(rst_n), .lamp_on(lamp_on), .status(motion_lockout_input));

	// ****************
	// helpers
	// ****************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// each channel is judged at the rising edge itself and released right after it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic hb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			hb = s_axi_bvalid;
			rsp = s_axi_bresp;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [11:0] a);
		logic hr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			hr = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [11:0] exp_thr(logic [11:0] c, int sh, bit low);
		logic [11:0] o;
		int v;
		for (int s = 0; s < 3; s++) begin
			v = int'(c[s*4 +: 4]) + sh;
			v = (v < 0) ? 0 : (v > 15) ? 15 : v;
			if (low) v = (v < int'(`BASIC_LOW_OFFSET)) ? 0 : v - int'(`BASIC_LOW_OFFSET);
			o[s*4 +: 4] = 4'(v);
		end
		return o;
	endfunction
	function automatic logic [4:0] exp_blk(logic [14:0] r, logic [2:0] m);
		logic [4:0] o;
		o = 5'h0;
		for (int s = 0; s < 3; s++) if (m[s]) o = o | r[s*5 +: 5];
		return o;
	endfunction

	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, lamp_on} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sector_motion, fail_count, checked, cyc} = '0;
		s_axi_wstrb = 4'hf;
		adjuster_pos = `ADJ_MID;
		void'($urandom(34669));
		wt(8);
		rst_n <= 1'b1;
		wt(2);
		chk(sector_threshold, `RST_SENS);
		rdr(`OFS_ROUTE);
		chk(rd, 32'h7fff);
		rdr(`OFS_LOCKOUT_TIME);
		chk(rd, 32'h000a);
		rdr(12'hff0);
		chk(rsp, 2'h2);
		chk(rd, 32'h0);
		wr(12'hff0, 32'h1);
		chk(rsp, 2'h2);
		for (int i = 0; i < 6; i++) begin
			rt = (i == 0) ? 15'h0 : 15'($urandom);
			wr(`OFS_ROUTE, {17'h0, rt});
			sector_motion <= (i == 5) ? 3'h7 : 3'($urandom);
			wt(8);
			chk(detection_block, exp_blk(rt, sector_motion));
		end
		sector_motion <= 3'h0;
		for (int i = 0; i < 4; i++) begin
			cfg = (i == 0) ? 12'hf01 : 12'($urandom);
			rem = 12'($urandom);
			wr(`OFS_SECTOR_SENS, {20'h0, cfg});
			wt(3);
			chk(sector_threshold, cfg);
			adjuster_pos <= `ADJ_UP;
			wt(8);
			chk(sector_threshold, exp_thr(cfg, 1, 0));
			adjuster_pos <= `ADJ_DOWN;
			wt(8);
			chk(sector_threshold, exp_thr(cfg, -1, 0));
			wr(`OFS_REMOTE_SENS, {20'h0, rem});
			wt(8);
			chk(sector_threshold, rem);
			adjuster_pos <= `ADJ_MID;
			wt(8);
			chk(sector_threshold, cfg);
		end
		wr(`OFS_CONFIG, 32'h3);
		wt(3);
		chk(sector_threshold, exp_thr(cfg, 0, 1));
		rdr(`OFS_EFFECTIVE_SENS);
		chk(rd, {20'h0, exp_thr(cfg, 0, 1)});
		wr(`OFS_CONFIG, 32'h1);
		wt(3);
		chk(sector_threshold, cfg);
		wr(`OFS_CONFIG, 32'h2);
		wt(3);
		chk(sector_threshold, cfg);
		wr(`OFS_LOCKOUT_TIME, 32'h5);
		sector_motion <= 3'h7;
		wt(8);
		chk(detection_block, exp_blk(rt, 3'h7));
		lamp_on <= 1'b1;
		wt(8);
		chk({lockout_active, detection_block}, 6'h20);
		lamp_on <= 1'b0;
		wt(20);
		chk(lockout_active, 1'b1);
		for (int i = 0; i < 40 && lockout_active; i++) wt(1);
		wt(2);
		chk({lockout_active, detection_block}, {1'b0, exp_blk(rt, 3'h7)});
		test_done;
	end
endmodule
